// [inc/ake_link_if.sv]
// Message link between the transmitter and receiver sequencers.
// Each message is a one-cycle valid pulse with a kind code and payload.
`timescale 1ns/10ps
interface ake_link_if;
  import ake_pkg::*;
  logic t2r_valid;
  logic [KIND_W-1:0] t2r_kind;
  logic [TDATA_W-1:0] t2r_data;
  logic r2t_valid;
  logic [KIND_W-1:0] r2t_kind;
  logic [RDATA_W-1:0] r2t_data;
  logic r2t_flag;
  modport tx (output t2r_valid, t2r_kind, t2r_data,
              input r2t_valid, r2t_kind, r2t_data, r2t_flag);
  modport rx (input t2r_valid, t2r_kind, t2r_data,
              output r2t_valid, r2t_kind, r2t_data, r2t_flag);
endinterface : ake_link_if

// [inc/ake_pkg.sv]
// Shared constants, message codes and helpers for the key exchange ends.
// Assumes a single 40 MHz clock shared by both ends.
package ake_pkg;
  // Clock and timeouts
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int UNPAIRED_MS = 1000;
  localparam int PAIRED_MS = 200;
  localparam int PAIR_MS = 200;
  localparam int UNPAIRED_CYC = UNPAIRED_MS * CYC_PER_MS;
  localparam int PAIRED_CYC = PAIRED_MS * CYC_PER_MS;
  localparam int PAIR_CYC = PAIR_MS * CYC_PER_MS;
  localparam int TMR_W = 26;

  // Field widths
  localparam int NONCE_W = 64;
  localparam int KEY_W = 128;
  localparam int RID_W = 40;
  localparam int HV_W = 256;
  localparam int CT_W = 1024;
  localparam int TDATA_W = 1024;
  localparam int RDATA_W = 256;
  localparam int KIND_W = 3;
  localparam int EKH_LSB = 128;

  // Message codes on the link
  localparam logic [KIND_W-1:0] MSG_INIT = 3'h1;
  localparam logic [KIND_W-1:0] MSG_UNPAIRED = 3'h2;
  localparam logic [KIND_W-1:0] MSG_PAIRED = 3'h3;
  localparam logic [KIND_W-1:0] MSG_CERT = 3'h4;
  localparam logic [KIND_W-1:0] MSG_RRX = 3'h5;
  localparam logic [KIND_W-1:0] MSG_VERIFY = 3'h6;
  localparam logic [KIND_W-1:0] MSG_PAIRREC = 3'h7;

  typedef enum logic [3:0] {
    TX_IDLE, TX_WAIT_CERT, TX_LOOKUP, TX_CERT_CHK, TX_ENCRYPT,
    TX_SRM_CHK, TX_WAIT_RRX, TX_DERIVE, TX_WAIT_H, TX_WAIT_PAIR,
    TX_DONE, TX_FAIL
  } ake_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_SEND_CERT, RX_WAIT_KEY, RX_WAIT_ENG, RX_SEND_PAIR
  } ake_rx_state_t;

  // Verification input: repeater flag folded into the nonce's lowest bit
  function automatic logic [NONCE_W-1:0] ake_h_input(
    input logic [NONCE_W-1:0] rtx, input logic rep);
    return rtx ^ {63'h0, rep};
  endfunction : ake_h_input

  // Pairing input: nonce in the upper half, zeros below
  function automatic logic [KEY_W-1:0] ake_pair_m(
    input logic [NONCE_W-1:0] rtx);
    return {rtx, 64'h0};
  endfunction : ake_pair_m
endpackage : ake_pkg

// [rtl/ake_rx.sv]
// Receiver end of the key exchange sequencer.
// Assumes an outside engine for decryption, key derivation and hashing.
`timescale 1ns/10ps
module ake_rx
  import ake_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  ake_link_if.rx lnk,
  input wire logic cfg_repeater,
  input wire logic [RID_W-1:0] cfg_rcv_id,
  input wire logic [NONCE_W-1:0] rnd_nonce,
  input wire logic eng_done,
  input wire logic eng_fail,
  input wire logic [HV_W-1:0] eng_h,
  input wire logic [KEY_W-1:0] eng_ekh,
  output logic eng_req,
  output logic eng_unpaired,
  output logic [TDATA_W-1:0] eng_payload,
  output logic [NONCE_W-1:0] eng_hmsg,
  output logic [NONCE_W-1:0] eng_rrx
);
  typedef struct packed {
    ake_rx_state_t st;
    logic valid;
    logic [KIND_W-1:0] kind;
    logic [RDATA_W-1:0] data;
    logic flag;
    logic [NONCE_W-1:0] rtx;
    logic [NONCE_W-1:0] rrx;
    logic [NONCE_W-1:0] hmsg;
    logic unpaired;
    logic [TDATA_W-1:0] payload;
    logic req;
    logic [KEY_W-1:0] ekh;
  } ake_rx_s_t;

  ake_rx_s_t s;
  ake_rx_s_t next_s;

  // Next state of the receiver
  always_comb begin
    next_s = s;
    next_s.valid = 1'b0;
    next_s.req = 1'b0;
    case (s.st)
      RX_SEND_CERT: begin
        next_s.valid = 1'b1;
        next_s.kind = MSG_CERT;
        next_s.data = {{(RDATA_W-RID_W){1'b0}}, cfg_rcv_id};
        next_s.flag = cfg_repeater;
        // Verify input fixed once the flag goes out
        next_s.hmsg = ake_h_input(s.rtx, cfg_repeater);
        next_s.st = RX_WAIT_KEY;
      end
      RX_WAIT_KEY: begin
        if (lnk.t2r_valid && (lnk.t2r_kind == MSG_UNPAIRED ||
            lnk.t2r_kind == MSG_PAIRED)) begin
          // Fresh nonce drawn only now and sent at once
          next_s.rrx = rnd_nonce;
          next_s.valid = 1'b1;
          next_s.kind = MSG_RRX;
          next_s.data = {{(RDATA_W-NONCE_W){1'b0}}, rnd_nonce};
          next_s.unpaired = (lnk.t2r_kind == MSG_UNPAIRED);
          next_s.payload = lnk.t2r_data;
          next_s.req = 1'b1;
          next_s.st = RX_WAIT_ENG;
        end
      end
      RX_WAIT_ENG: begin
        if (eng_done) begin
          if (eng_fail) begin
            next_s.st = RX_IDLE;
          end else begin
            next_s.valid = 1'b1;
            next_s.kind = MSG_VERIFY;
            next_s.data = eng_h;
            next_s.ekh = eng_ekh;
            next_s.st = s.unpaired ? RX_SEND_PAIR : RX_IDLE;
          end
        end
      end
      RX_SEND_PAIR: begin
        next_s.valid = 1'b1;
        next_s.kind = MSG_PAIRREC;
        next_s.data = {{(RDATA_W-KEY_W){1'b0}}, s.ekh};
        next_s.st = RX_IDLE;
      end
      default: begin
        next_s.st = RX_IDLE;
      end
    endcase
    // Initiation restarts the exchange from any state
    if (lnk.t2r_valid && lnk.t2r_kind == MSG_INIT) begin
      next_s.rtx = lnk.t2r_data[NONCE_W-1:0];
      next_s.st = RX_SEND_CERT;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign lnk.r2t_valid = s.valid;
  assign lnk.r2t_kind = s.kind;
  assign lnk.r2t_data = s.data;
  assign lnk.r2t_flag = s.flag;
  assign eng_req = s.req;
  assign eng_unpaired = s.unpaired;
  assign eng_payload = s.payload;
  assign eng_hmsg = s.hmsg;
  assign eng_rrx = s.rrx;
endmodule : ake_rx

// [rtl/ake_tx.sv]
// Transmitter end of the key exchange sequencer.
// Assumes outside engines for lookup, signature, RSA, RENEWABILITY_MESSAGE and HMAC work.
//
// Contract
// - Initiate with fresh 64-bit nonce
// - Receiver answers certificate; latch repeater flag
// - Unpaired: verify certificate signature, abort on failure
// - Unpaired: random master key, send 1024-bit ciphertext
// - Renewability signature checked; failure aborts (code checks it only when top_level is set)
// - Top level only: revocation hit aborts
// - Latch 64-bit receiver nonce
// - Derived key is counter0 then counter1 halves
// - Verify value: HMAC over nonce xor repeater
// - Unpaired: verify within one second, matching
// - Paired: send stored encrypted key and pairing input
// - Paired: verify within 200 ms, matching
// - Receiver nonce drawn and sent after key
// - Receiver decrypts, derives, sends verify promptly
// - Receiver stays silent on decryption failure
// - Receiver paired decrypt with private-key hash
// - Receiver sends encrypted master key record
// - Store pairing input, key, encrypted key
// - Pairing record within 200 ms of verify
// - Pairing input is nonce then 64 zeros
// - New attempt may start any time
`timescale 1ns/10ps
module ake_tx
  import ake_pkg::*;
#(
  parameter int UNPAIRED_LIM = UNPAIRED_CYC,
  parameter int PAIRED_LIM = PAIRED_CYC,
  parameter int PAIR_LIM = PAIR_CYC
)(
  input wire logic mclk,
  input wire logic rst_b,
  ake_link_if.tx lnk,
  input wire logic start,
  input wire logic top_level,
  input wire logic [NONCE_W-1:0] rnd_nonce,
  input wire logic [KEY_W-1:0] rnd_km,
  input wire logic lookup_done,
  input wire logic lookup_hit,
  input wire logic [KEY_W-1:0] lookup_km,
  input wire logic [KEY_W-1:0] lookup_ekh,
  input wire logic [KEY_W-1:0] lookup_m,
  input wire logic cert_done,
  input wire logic cert_ok,
  input wire logic enc_done,
  input wire logic [CT_W-1:0] enc_ct,
  input wire logic srm_done,
  input wire logic srm_ok,
  input wire logic srm_revoked,
  input wire logic kd_done,
  input wire logic [HV_W-1:0] kd_h,
  output logic lookup_req,
  output logic [RID_W-1:0] rcv_id,
  output logic cert_req,
  output logic enc_req,
  output logic srm_req,
  output logic kd_req,
  output logic [NONCE_W-1:0] kd_hmsg,
  output logic [NONCE_W-1:0] kd_rtx,
  output logic [NONCE_W-1:0] kd_rrx,
  output logic [KEY_W-1:0] kd_km,
  output logic repeater,
  output logic store_stb,
  output logic [KEY_W-1:0] store_m,
  output logic [KEY_W-1:0] store_ekh,
  output logic done,
  output logic fail
);
  // Refuse timeouts the timer cannot hold
  if (UNPAIRED_LIM < 1 || UNPAIRED_LIM >= 2**TMR_W ||
      PAIRED_LIM < 1 || PAIRED_LIM >= 2**TMR_W ||
      PAIR_LIM < 1 || PAIR_LIM >= 2**TMR_W) begin : g_bad_lim
    $error("ake_tx: timeout limit out of timer range");
  end

  localparam logic [TMR_W-1:0] UNP_T = UNPAIRED_LIM[TMR_W-1:0];
  localparam logic [TMR_W-1:0] PRD_T = PAIRED_LIM[TMR_W-1:0];
  localparam logic [TMR_W-1:0] PAIR_T = PAIR_LIM[TMR_W-1:0];

  typedef struct packed {
    ake_tx_state_t st;
    logic valid;
    logic [KIND_W-1:0] kind;
    logic [TDATA_W-1:0] data;
    logic [NONCE_W-1:0] rtx;
    logic [NONCE_W-1:0] rrx;
    logic [NONCE_W-1:0] hmsg;
    logic [KEY_W-1:0] km;
    logic [KEY_W-1:0] ekh;
    logic [KEY_W-1:0] m;
    logic rep;
    logic [RID_W-1:0] rid;
    logic stored;
    logic armed;
    logic [TMR_W-1:0] tmr;
    logic rrx_got;
    logic h_got;
    logic pr_got;
    logic [HV_W-1:0] hp;
    logic [HV_W-1:0] hloc;
    logic lookup_req;
    logic cert_req;
    logic enc_req;
    logic srm_req;
    logic kd_req;
    logic store_stb;
    logic done;
    logic fail;
  } ake_tx_s_t;

  ake_tx_s_t s;
  ake_tx_s_t next_s;
  logic abort;

  // Next state of the transmitter
  always_comb begin
    next_s = s;
    abort = 1'b0;
    next_s.valid = 1'b0;
    next_s.lookup_req = 1'b0;
    next_s.cert_req = 1'b0;
    next_s.enc_req = 1'b0;
    next_s.srm_req = 1'b0;
    next_s.kd_req = 1'b0;
    next_s.store_stb = 1'b0;

    // Replies accepted once a key message has gone out
    if (s.armed && lnk.r2t_valid) begin
      if (lnk.r2t_kind == MSG_RRX && !s.rrx_got) begin
        next_s.rrx = lnk.r2t_data[NONCE_W-1:0];
        next_s.rrx_got = 1'b1;
      end
      if (lnk.r2t_kind == MSG_VERIFY && !s.h_got) begin
        next_s.hp = lnk.r2t_data;
        next_s.h_got = 1'b1;
        if (!s.stored) begin
          next_s.tmr = PAIR_T;
        end
      end
      if (lnk.r2t_kind == MSG_PAIRREC && s.h_got && !s.stored &&
          !s.pr_got) begin
        next_s.ekh = lnk.r2t_data[KEY_W-1:0];
        next_s.pr_got = 1'b1;
      end
    end

    // Reply timer counts down while armed
    if (s.armed && s.tmr != '0 && next_s.tmr == s.tmr) begin
      next_s.tmr = s.tmr - 1'b1;
    end

    case (s.st)
      TX_WAIT_CERT: begin
        if (lnk.r2t_valid && lnk.r2t_kind == MSG_CERT) begin
          next_s.rep = lnk.r2t_flag;
          next_s.hmsg = ake_h_input(s.rtx, lnk.r2t_flag);
          next_s.rid = lnk.r2t_data[RID_W-1:0];
          next_s.lookup_req = 1'b1;
          next_s.st = TX_LOOKUP;
        end
      end
      TX_LOOKUP: begin
        if (lookup_done) begin
          next_s.stored = lookup_hit;
          if (lookup_hit) begin
            next_s.km = lookup_km;
            next_s.ekh = lookup_ekh;
            next_s.m = lookup_m;
            next_s.valid = 1'b1;
            next_s.kind = MSG_PAIRED;
            next_s.data = {{(TDATA_W-2*KEY_W){1'b0}}, lookup_ekh,
                           lookup_m};
            next_s.armed = 1'b1;
            next_s.tmr = PRD_T;
            next_s.srm_req = top_level;
            next_s.st = top_level ? TX_SRM_CHK : TX_WAIT_RRX;
          end else begin
            next_s.cert_req = 1'b1;
            next_s.st = TX_CERT_CHK;
          end
        end
      end
      TX_CERT_CHK: begin
        if (cert_done) begin
          if (!cert_ok) begin
            abort = 1'b1;
          end else begin
            next_s.km = rnd_km;
            next_s.enc_req = 1'b1;
            next_s.st = TX_ENCRYPT;
          end
        end
      end
      TX_ENCRYPT: begin
        if (enc_done) begin
          next_s.valid = 1'b1;
          next_s.kind = MSG_UNPAIRED;
          next_s.data = enc_ct;
          next_s.armed = 1'b1;
          next_s.tmr = UNP_T;
          next_s.srm_req = top_level;
          next_s.st = top_level ? TX_SRM_CHK : TX_WAIT_RRX;
        end
      end
      TX_SRM_CHK: begin
        if (srm_done) begin
          if (!srm_ok || srm_revoked) begin
            abort = 1'b1;
          end else begin
            next_s.st = TX_WAIT_RRX;
          end
        end
      end
      TX_WAIT_RRX: begin
        if (s.rrx_got) begin
          next_s.kd_req = 1'b1;
          next_s.st = TX_DERIVE;
        end
      end
      TX_DERIVE: begin
        if (kd_done) begin
          next_s.hloc = kd_h;
          next_s.st = TX_WAIT_H;
        end
      end
      TX_WAIT_H: begin
        if (s.h_got) begin
          if (s.hp != s.hloc) begin
            abort = 1'b1;
          end else if (s.stored) begin
            next_s.armed = 1'b0;
            next_s.done = 1'b1;
            next_s.st = TX_DONE;
          end else begin
            next_s.st = TX_WAIT_PAIR;
          end
        end
      end
      TX_WAIT_PAIR: begin
        if (s.pr_got) begin
          next_s.m = ake_pair_m(s.rtx);
          next_s.store_stb = 1'b1;
          next_s.armed = 1'b0;
          next_s.done = 1'b1;
          next_s.st = TX_DONE;
        end
      end
      TX_IDLE, TX_DONE, TX_FAIL: begin
        next_s.st = s.st;
      end
      default: begin
        next_s.st = TX_IDLE;
      end
    endcase

    // Missing verify or pairing record when the timer runs out
    if (s.armed && s.tmr == '0 && (!next_s.h_got ||
        (s.h_got && !s.stored && !next_s.pr_got))) begin
      abort = 1'b1;
    end

    // Abort wipes session secrets and stops the timer
    if (abort) begin
      next_s = '0;
      next_s.st = TX_FAIL;
      next_s.fail = 1'b1;
    end

    // A new attempt pre-empts whatever is in flight
    if (start) begin
      next_s = '0;
      next_s.rtx = rnd_nonce;
      next_s.valid = 1'b1;
      next_s.kind = MSG_INIT;
      next_s.data = {{(TDATA_W-NONCE_W){1'b0}}, rnd_nonce};
      next_s.st = TX_WAIT_CERT;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign lnk.t2r_valid = s.valid;
  assign lnk.t2r_kind = s.kind;
  assign lnk.t2r_data = s.data;
  assign lookup_req = s.lookup_req;
  assign rcv_id = s.rid;
  assign cert_req = s.cert_req;
  assign enc_req = s.enc_req;
  assign srm_req = s.srm_req;
  assign kd_req = s.kd_req;
  assign kd_hmsg = s.hmsg;
  assign kd_rtx = s.rtx;
  assign kd_rrx = s.rrx;
  assign kd_km = s.km;
  assign repeater = s.rep;
  assign store_stb = s.store_stb;
  assign store_m = s.m;
  assign store_ekh = s.ekh;
  assign done = s.done;
  assign fail = s.fail;
endmodule : ake_tx

// [tb/ake_link_asserts.sv]
// Link checker for the two key exchange ends.
// Assumes it watches the one link that joins two design ends.
`timescale 1ns/10ps
module ake_link_asserts
  import ake_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic t2r_valid,
  input wire logic [KIND_W-1:0] t2r_kind,
  input wire logic [TDATA_W-1:0] t2r_data,
  input wire logic r2t_valid,
  input wire logic [KIND_W-1:0] r2t_kind,
  input wire logic [RDATA_W-1:0] r2t_data,
  input wire logic r2t_flag
);
  logic unp;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Remembers which key transport went out last
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      unp <= 1'b0;
    end else if (t2r_valid && t2r_kind != MSG_INIT) begin
      unp <= (t2r_kind == MSG_UNPAIRED);
    end
  end
  property p_tx_pulse;
    t2r_valid |=> !t2r_valid;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse)
    else $error("tx message held past one cycle");
  property p_init_data;
    t2r_valid && t2r_kind == MSG_INIT |-> t2r_data[TDATA_W-1:NONCE_W] == '0;
  endproperty
  a_init_data: assert property (p_init_data)
    else $error("init message carries more than a nonce");
  property p_cert;
    t2r_valid && t2r_kind == MSG_INIT |-> ##2 r2t_valid && r2t_kind == MSG_CERT;
  endproperty
  a_cert: assert property (p_cert)
    else $error("certificate reply missing");
  property p_flag;
    $changed(r2t_flag) |-> r2t_valid && r2t_kind == MSG_CERT;
  endproperty
  a_flag: assert property (p_flag)
    else $error("repeater flag moved outside a certificate reply");
  property p_rrx;
    t2r_valid && t2r_kind != MSG_INIT |=> r2t_valid && r2t_kind == MSG_RRX;
  endproperty
  a_rrx: assert property (p_rrx)
    else $error("receiver nonce not sent after key transport");
  property p_rrx_cause;
    r2t_valid && r2t_kind == MSG_RRX |->
      $past(t2r_valid) && $past(t2r_kind) != MSG_INIT;
  endproperty
  a_rrx_cause: assert property (p_rrx_cause)
    else $error("receiver nonce sent without key transport");
  property p_pairrec;
    r2t_valid && r2t_kind == MSG_VERIFY && unp |=>
      r2t_valid && r2t_kind == MSG_PAIRREC;
  endproperty
  a_pairrec: assert property (p_pairrec)
    else $error("pairing record missing after verify");
  property p_no_pairrec;
    r2t_valid && r2t_kind == MSG_VERIFY && !unp |=> !r2t_valid;
  endproperty
  a_no_pairrec: assert property (p_no_pairrec)
    else $error("pairing record sent in paired case");
  property p_paired_data;
    t2r_valid && t2r_kind == MSG_PAIRED |-> t2r_data[TDATA_W-1:256] == '0;
  endproperty
  a_paired_data: assert property (p_paired_data)
    else $error("paired key message has stray upper bits");
endmodule : ake_link_asserts

// [tb/auth_key_exchange_sequencer_tb_top.sv]
// Bench joining both key exchange ends over one link.
// Assumes engines answer 1 ns after each request, within the same cycle.
`timescale 1ns/10ps
module auth_key_exchange_sequencer_tb_top
  import ake_pkg::*;
;
  logic mclk = 0, rst_b = 0, start = 0, top_level = 0, rep = 0;
  logic c_bad = 0, s_bad = 0, revk = 0, hbad = 0, dfail = 0, hit = 0;
  logic lookup_done = 0, cert_done = 0, enc_done = 0;
  logic srm_done = 0, kd_done = 0, eng_done = 0;
  logic lookup_req, cert_req, enc_req, srm_req, kd_req, eng_req;
  logic repeater, store_stb, done, fail, eng_unpaired;
  logic [NONCE_W-1:0] rtx = 64'h0, rrx = 64'h1357_9BDF_0246_8ACE;
  logic [NONCE_W-1:0] kd_hmsg, kd_rtx, kd_rrx, eng_hmsg, eng_rrx, init_d;
  logic [KEY_W-1:0] km = {2{64'h0F0E_0D0C_0B0A_0908}};
  logic [KEY_W-1:0] lk_km = {2{64'h7766_5544_3322_1100}};
  logic [KEY_W-1:0] lk_ekh = {2{64'hCAFE_F00D_1234_5678}};
  logic [KEY_W-1:0] lk_m = {64'h9988_7766_5544_3322, 64'h0};
  logic [KEY_W-1:0] ekh = {2{64'hABCD_0123_4567_89EF}};
  logic [KEY_W-1:0] kd_km, store_m, store_ekh, st_m, st_e, st_k;
  logic [RID_W-1:0] rid = 40'hA5_5A0F_F0C3, rcv_id;
  logic [HV_W-1:0] hv = {4{64'hFEDC_BA98_7654_3210}};
  logic [TDATA_W-1:0] key_d, eng_payload;
  logic [5:0] tbl [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h03, 6'h05};
  int error_cnt = 0, n_compared = 0, cyc = 0, key_cyc = 0;
  int srm_n = 0, st_n = 0;
  ake_link_if lnk();
  ake_tx #(.UNPAIRED_LIM(50), .PAIRED_LIM(20), .PAIR_LIM(20)) ake_tx_inst (
    .mclk, .rst_b, .lnk(lnk), .start, .top_level, .rnd_nonce(rtx),
    .rnd_km(km), .lookup_done, .lookup_hit(hit), .lookup_km(lk_km),
    .lookup_ekh(lk_ekh), .lookup_m(lk_m), .cert_done, .cert_ok(!c_bad),
    .enc_done, .enc_ct({8{kd_km}}), .srm_done, .srm_ok(!s_bad),
    .srm_revoked(revk), .kd_done, .kd_h(hv), .lookup_req, .rcv_id,
    .cert_req, .enc_req, .srm_req, .kd_req, .kd_hmsg, .kd_rtx, .kd_rrx,
    .kd_km, .repeater, .store_stb, .store_m, .store_ekh, .done, .fail);
  ake_rx ake_rx_inst (
    .mclk, .rst_b, .lnk(lnk), .cfg_repeater(rep), .cfg_rcv_id(rid),
    .rnd_nonce(rrx), .eng_done, .eng_fail(dfail), .eng_h(hv ^ {255'h0, hbad}),
    .eng_ekh(ekh), .eng_req, .eng_unpaired, .eng_payload, .eng_hmsg,
    .eng_rrx);
  ake_link_asserts ake_link_asserts_inst (
    .mclk, .rst_b, .t2r_valid(lnk.t2r_valid), .t2r_kind(lnk.t2r_kind),
    .t2r_data(lnk.t2r_data), .r2t_valid(lnk.r2t_valid),
    .r2t_kind(lnk.r2t_kind), .r2t_data(lnk.r2t_data),
    .r2t_flag(lnk.r2t_flag));
  // Clock at 40 MHz
  always #12.5 mclk = ~mclk;
  // Engines answer each request 1 ns later, in the same cycle
  always @(posedge mclk) begin
    #1;
    lookup_done = lookup_req;
    cert_done = cert_req;
    enc_done = enc_req;
    srm_done = srm_req;
    kd_done = kd_req;
    eng_done = eng_req;
  end
  // Captures transmitter link traffic, store strobes and renewability check requests
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (lnk.t2r_valid === 1'b1 && lnk.t2r_kind === MSG_INIT) begin
      init_d <= lnk.t2r_data[NONCE_W-1:0];
    end else if (lnk.t2r_valid === 1'b1) begin
      key_d <= lnk.t2r_data;
      key_cyc <= cyc;
    end
    if (srm_req === 1'b1) srm_n <= srm_n + 1;
    if (store_stb === 1'b1) begin
      st_n <= st_n + 1;
      st_m <= store_m;
      st_e <= store_ekh;
      st_k <= kd_km;
    end
  end
  task automatic chk(input string nm, input logic [TDATA_W-1:0] e,
                     input logic [TDATA_W-1:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // Pulses start with a nonce and waits for done or fail
  task automatic run(input logic [NONCE_W-1:0] n);
    int w;
    @(posedge mclk);
    #1 start = 1;
    rtx = n;
    @(posedge mclk);
    #1 start = 0;
    for (w = 0; w < 400 && done !== 1'b1 && fail !== 1'b1; w++) begin
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    #1;
  endtask : run
  task automatic t_unpaired(input logic r, input logic t);
    logic [NONCE_W-1:0] n;
    int s0, q0;
    n = {56'hA1B2C3D4E5F607, 6'h0, r, t};
    {c_bad, s_bad, hbad, dfail, hit} = 5'h0;
    {revk, rep, top_level} = {!t, r, t};
    km = ~km;
    s0 = srm_n;
    q0 = st_n;
    run(n);
    chk("done", 1, done);
    chk("repeater", r, repeater);
    chk("init nonce", n, init_d);
    chk("ciphertext", {8{km}}, key_d);
    chk("h input", n ^ {63'h0, r}, kd_hmsg);
    chk("rx h input", n ^ {63'h0, r}, eng_hmsg);
    chk("rrx", rrx, kd_rrx);
    chk("rx rrx", rrx, eng_rrx);
    chk("srm reqs", t, srm_n - s0);
    chk("stores", 1, st_n - q0);
    chk("store m", {n, 64'h0}, st_m);
    chk("store ekh", ekh, st_e);
    chk("store km", km, st_k);
    chk("rcv id", rid, rcv_id);
    $display("unpaired test rep=%0d top=%0d ended", r, t);
  endtask : t_unpaired
  task automatic t_paired(input logic r);
    logic [NONCE_W-1:0] n;
    int q0;
    n = {56'h5A5A5A5A5A5A5A, 7'h0, r};
    {c_bad, s_bad, revk, hbad, dfail, hit} = 6'h01;
    {rep, top_level} = {r, 1'b1};
    q0 = st_n;
    run(n);
    chk("done", 1, done);
    chk("key msg", {768'h0, lk_ekh, lk_m}, key_d);
    chk("rx key msg", {768'h0, lk_ekh, lk_m}, eng_payload);
    chk("rx paired", 0, eng_unpaired);
    chk("km", lk_km, kd_km);
    chk("h input", n ^ {63'h0, r}, kd_hmsg);
    chk("no store", 0, st_n - q0);
    $display("paired test rep=%0d ended", r);
  endtask : t_paired
  task automatic t_abort(input int m);
    int lim, d;
    {c_bad, s_bad, revk, hbad, dfail, hit} = tbl[m];
    top_level = 1;
    run(64'h0BAD_0000_0000_0000 + m);
    d = cyc - key_cyc;
    lim = (m == 4) ? 50 : 20;
    chk("fail", 1, fail);
    chk("done", 0, done);
    chk("nonce cleared", 0, kd_rtx);
    chk("km cleared", 0, kd_km);
    if (m == 4 || m == 5) chk("wait span", 1, d >= lim && d <= lim + 6);
    if (m == 6) chk("early fail", 1, d < 20);
    $display("abort test mode=%0d ended", m);
  endtask : t_abort
  task automatic t_restart;
    {c_bad, s_bad, revk, hbad, dfail, hit} = 6'h00;
    @(posedge mclk);
    #1 start = 1;
    rtx = 64'h1111_1111_2222_2222;
    @(posedge mclk);
    #1 start = 0;
    repeat (6) @(posedge mclk);
    run(64'h3333_4444_5555_6666);
    chk("new init", 64'h3333_4444_5555_6666, init_d);
    chk("new nonce", 64'h3333_4444_5555_6666, kd_rtx);
    chk("done", 1, done);
    $display("restart test ended");
  endtask : t_restart
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence after six cycles of reset
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst_b = 1;
    for (int i = 0; i < 4; i++) t_unpaired(i[1], i[0]);
    t_paired(0);
    t_paired(1);
    for (int m = 0; m < 7; m++) t_abort(m);
    t_restart;
    tally_and_finish;
  end
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    tally_and_finish;
  end
endmodule : auth_key_exchange_sequencer_tb_top
